// ==== bench/mbc_chk.sv ====
// Port assertions for the block checksum top module
`timescale 1ns/1ps
module mbc_chk
  import mbc_pkg::*;
#(
  parameter int BIT_CYC = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Parallel port
  input wire logic [2:0] addr,
  input wire logic strobe,
  input wire logic wr_n,
  input wire logic [7:0] data_out,
  input wire logic data_oe_n,
  // Serial side and status
  input wire logic rx_frame_found,
  input wire logic tx_bit_en,
  input wire logic frame_detect_en,
  input wire logic low_power
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  localparam int MAXB = 65 * BIT_CYC + 8;
  localparam int MINB = 63 * BIT_CYC;
  int busy;
  // Cycles spent on one block; assumes rx stays enabled until it ends
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) busy <= 0;
    else if (frame_detect_en && !rx_frame_found) busy <= 0;
    else if (rx_frame_found || busy > 0) busy <= busy + 1;
  end
  a_oe_on_read: assert property (strobe && wr_n |-> !data_oe_n)
    else $error("bus not driven on read");
  a_oe_off_write: assert property (!strobe || !wr_n |-> data_oe_n)
    else $error("bus driven outside read");
  a_unmapped_zero: assert property ((addr == 3'h1 || addr == 3'h3) && $stable(addr)
    |=> data_out == 8'h00) else $error("unmapped read not zero");
  a_synd_stands: assert property (addr == ADDR_SYND_LOW && $past(addr) == ADDR_SYND_LOW
    && frame_detect_en && $past(frame_detect_en, 3) |=> $stable(data_out))
    else $error("syndrome moved between blocks");
  a_frame_blocks: assert property (rx_frame_found && frame_detect_en
    |-> ##[1:4] !frame_detect_en [*8]) else $error("frame detect left on in block");
  a_sleep_no_tx: assert property (low_power |-> !tx_bit_en)
    else $error("sleeping while sending");
  a_sleep_no_rx: assert property (frame_detect_en |-> !low_power)
    else $error("sleeping with receiver on");
  a_block_long: assert property (busy <= MAXB)
    else $error("block check too long");
  a_block_short: assert property ($rose(frame_detect_en) && busy > 0 |-> busy >= MINB)
    else $error("block check too short");
  c_frame: cover property (rx_frame_found);
  c_tx_start: cover property ($rose(tx_bit_en));
  c_synd_read: cover property (strobe && wr_n && addr == ADDR_SYND_HIGH);
endmodule
bind mbc_top mbc_chk #(.BIT_CYC(BIT_CYC)) chk (.sys_clk(sys_clk), .rst(rst), .addr(addr),
  .strobe(strobe), .wr_n(wr_n), .data_out(data_out), .data_oe_n(data_oe_n),
  .rx_frame_found(rx_frame_found), .tx_bit_en(tx_bit_en),
  .frame_detect_en(frame_detect_en), .low_power(low_power));

// ==== bench/mbc_far.sv ====
// Far-end modem model: records the sent block and echoes it back
`timescale 1ns/1ps
module mbc_far #(
  parameter int BIT_CYC = 4
) (
  // Clock
  input wire logic sys_clk,
  // Bench commands
  input wire logic arm,
  input wire logic [6:0] err_pos,
  // Serial link
  input wire logic tx_bit_out,
  input wire logic tx_bit_en,
  output logic rx_bit_in,
  output logic rx_frame_found,
  // Recorded block, first bit at the top
  output logic [63:0] cap
);
  int cyc = 0;
  logic [6:0] bitn = 7'h40;
  logic en_q = 1'b0;
  logic lead = 1'b0;
  logic alt = 1'b0;
  // Outside a block show a toggling level, never a stale bit
  assign rx_bit_in = (bitn < 7'h40) ? tx_bit_out ^ (bitn == err_pos) : alt;
  // Enable leads the first bit by one bit period; frame pulse marks bit 0
  always @(posedge sys_clk) begin
    en_q <= tx_bit_en;
    alt <= ~alt;
    rx_frame_found <= arm && lead && cyc == BIT_CYC - 1;
    if (tx_bit_en && !en_q) begin
      cyc <= 1;
      lead <= 1'b1;
    end else if (lead || bitn < 7'h40) begin
      if (!lead && cyc == BIT_CYC / 2) cap[63 - bitn] <= tx_bit_out;
      cyc <= (cyc == BIT_CYC - 1) ? 0 : cyc + 1;
      if (cyc == BIT_CYC - 1) begin
        lead <= 1'b0;
        bitn <= lead ? 7'h00 : bitn + 7'h01;
      end
    end
  end
endmodule

// ==== bench/mbc_top_tb.sv ====
// Self-checking bench for the block checksum top module
`timescale 1ns/1ps
module mbc_top_tb;
  import mbc_pkg::*;
  logic sys_clk;
  logic rst;
  logic [2:0] addr;
  logic strobe, wr_n, data_oe_n;
  logic [7:0] data_in, data_out, q;
  logic rx_bit_in, rx_frame_found, tx_bit_out, tx_bit_en;
  logic frame_detect_en, low_power, arm;
  logic [6:0] err_pos;
  logic [63:0] cap;
  logic [15:0] exp_s;
  int fails = 0;
  int checked = 0;
  mbc_top #(.BIT_CYC(4)) dut (.*);
  mbc_far #(.BIT_CYC(4)) far (.*);
  // Clock at 40 MHz
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Watchdog: the tests need well under 4000 cycles
  initial begin
    #500000;
    fails++;
    test_done;
  end
  task test_done;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // Serial divider, bits taken from v[62] downwards
  function automatic logic [14:0] divide(input logic [62:0] v, input int n);
    logic [14:0] r;
    r = CRC_RESET;
    for (int i = 62; i > 62 - n; i--) begin
      r = {r[13:0], 1'b0} ^ ((v[i] ^ r[14]) ? CRC_POLY : 15'h0000);
    end
    return r;
  endfunction
  // One strobe cycle; entered and left just after a clock edge
  task acc(input logic w, input logic [2:0] a, input logic [7:0] d);
    addr = a;
    wr_n = !w;
    data_in = d;
    strobe = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    q = data_out;
    strobe = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask
  // Send six bytes, let the far end echo them with bit p flipped
  task run_block(input logic [47:0] m, input logic [6:0] p);
    logic [14:0] r;
    r = divide({m, 15'h0000}, 48) ^ 15'h0001;
    exp_s = (p > 7'd63) ? 16'h0000 : 16'h8000;
    if (p < 7'd63) exp_s[14:0] = divide(63'h1 << (62 - p), 63);
    err_pos = p;
    arm = 1'b1;
    for (int b = 5; b >= 0; b--) begin
      q = 8'h00;
      for (int t = 0; t < 40 && !q[ST_TX_READY]; t++) acc(0, ADDR_STATUS, 8'h00);
      acc(1, ADDR_TX_DATA, m[8 * b +: 8]);
    end
    arm = 1'b0;
    for (int t = 0; t < 600 && tx_bit_en; t++) @(posedge sys_clk);
    for (int t = 0; t < 100 && !frame_detect_en; t++) @(posedge sys_clk);
    #1;
    cmp("message bits", m, cap[63:16]);
    cmp("check word", {r, ^{m, r}}, cap[15:0]);
    acc(0, ADDR_SYND_LOW, 8'h00);
    cmp("syndrome low", exp_s[7:0], q);
    acc(0, ADDR_SYND_HIGH, 8'h00);
    cmp("syndrome high", exp_s[15:8], q);
    acc(0, ADDR_STATUS, 8'h00);
    cmp("checksum pass", p > 7'd63, q[ST_RX_PASS]);
    acc(0, ADDR_RX_DATA, 8'h00);
    cmp("last rx byte", cap[7:0] ^ {7'h00, p == 7'd63}, q);
  endtask
  // Main sequence
  initial begin
    rst = 1'b1;
    strobe = 1'b0;
    wr_n = 1'b1;
    addr = 3'h0;
    data_in = 8'h00;
    arm = 1'b0;
    err_pos = 7'h7f;
    repeat (20) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    cmp("low power at reset", 1'b1, low_power);
    acc(1, ADDR_CONTROL, 8'h04);
    cmp("low power rx on", 1'b0, low_power);
    cmp("frame detect idle", 1'b1, frame_detect_en);
    acc(0, 3'h1, 8'h00);
    cmp("unmapped read", 8'h00, q);
    acc(1, ADDR_CONTROL, 8'h07);
    run_block(48'h0000_0000_0000, 7'h7f);
    run_block(48'hffff_ffff_ffff, 7'd5);
    run_block(48'h8001_7e42_19bd, 7'd63);
    run_block(48'h3c5a_0f81_e7d2, 7'd55);
    acc(1, ADDR_SYND_LOW, 8'ha5);
    acc(0, ADDR_SYND_LOW, 8'h00);
    cmp("syndrome read only", exp_s[7:0], q);
    acc(1, ADDR_CONTROL, 8'h00);
    cmp("low power all off", 1'b1, low_power);
    test_done;
  end
endmodule

// ==== rtl/mbc_bitclk.sv ====
// Modem bit-period tick generator
`timescale 1ns/1ps
module mbc_bitclk #(
  parameter int CYCLES = 33333
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Run control and tick
  input wire logic run,
  output logic tick
);
  import mbc_pkg::*;
  logic [15:0] cnt;
  logic at_end;
  assign at_end = (cnt == 16'(CYCLES - 1));
  // Free count while running; restart aligns bits to the enable
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt <= 16'h0000;
      tick <= 1'b0;
    end else begin
      tick <= run && at_end;
      if (!run || at_end) begin
        cnt <= 16'h0000;
      end else begin
        cnt <= cnt + 16'h0001;
      end
    end
  end
endmodule

// ==== rtl/mbc_lfsr.sv ====
// Bit-serial divider by the block check polynomial
`timescale 1ns/1ps
module mbc_lfsr #(
  parameter int WIDTH = 15
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Control
  input wire logic clear,
  input wire logic shift,
  input wire logic din,
  // Remainder
  output logic [WIDTH-1:0] rem
);
  import mbc_pkg::*;
  logic fb;
  logic [WIDTH-1:0] next_rem;
  // Feedback of the top bit folds the polynomial back in
  assign fb = rem[WIDTH-1] ^ din;
  assign next_rem = {rem[WIDTH-2:0], 1'b0} ^ (fb ? CRC_POLY : CRC_RESET);
  // Divider register, cleared per block
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rem <= CRC_RESET;
    end else if (clear) begin
      rem <= CRC_RESET;
    end else if (shift) begin
      rem <= next_rem;
    end
  end
endmodule

// ==== rtl/mbc_pkg.sv ====
// Constants shared by the modem block checksum design
package mbc_pkg;
  // ********************************************************************
  // Register addresses {a2,a1,a0}
  // ********************************************************************
  localparam logic [2:0] ADDR_SYND_LOW = 3'h4;
  localparam logic [2:0] ADDR_SYND_HIGH = 3'h5;
  localparam logic [2:0] ADDR_CONTROL = 3'h0;
  localparam logic [2:0] ADDR_TX_DATA = 3'h2;
  localparam logic [2:0] ADDR_RX_DATA = 3'h6;
  localparam logic [2:0] ADDR_STATUS = 3'h7;
  // ********************************************************************
  // Control bits, status bits and field positions
  // ********************************************************************
  localparam int CTL_TX_EN = 0;
  localparam int CTL_TX_CHECK = 1;
  localparam int CTL_RX_EN = 2;
  localparam int ST_RX_READY = 0;
  localparam int ST_RX_PASS = 1;
  localparam int ST_TX_READY = 3;
  localparam int ST_TX_IDLE = 4;
  localparam int SYND_PARITY_BIT = 7;
  // ********************************************************************
  // Checksum arithmetic
  // ********************************************************************
  localparam int CRC_W = 15;
  localparam logic [14:0] CRC_POLY = 15'h6815;
  localparam logic [14:0] CRC_RESET = 15'h0000;
  localparam int BLOCK_BYTES = 6;
  localparam int MSG_BITS = 48;
  localparam int BLOCK_BITS = 64;
  localparam int BYTE_BITS = 8;
  // ********************************************************************
  // Timing: one modem bit is 1/1200 s at 40 MHz
  // ********************************************************************
  localparam int CLK_HZ = 40000000;
  localparam int BAUD = 1200;
  localparam int BIT_CYCLES = CLK_HZ / BAUD;
  localparam int BYTE_PERIODS_SYND = 8;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  typedef enum logic [1:0] {
    MBC_TX_IDLE = 2'b00,
    MBC_TX_DATA = 2'b01,
    MBC_TX_CHECK = 2'b10
  } mbc_tx_state_e;
endpackage

// ==== rtl/mbc_top.sv ====
// Block checksum generation and syndrome checking for the FFSK modem
`timescale 1ns/1ps
// Operation
// R1: Syndrome bits 1..15 are receive divider remainder
// R2: Syndrome valid at second check byte ready
// R3: Low byte S1..S8; high byte S9..S15, parity
// R4: Parity error flag on parity mismatch
// R5: Transmit divides 48 message bits by polynomial
// R6: Invert last remainder bit, append even parity
// R7: Send remainder then parity as check word
// R8: Receive divides 63 bits, bit 63 inverted
// R9: Receive even parity of 63 bits vs bit 64
// R10: Pass flag needs zero remainder and parity match
// R11: Low power only with both directions disabled
// R12: Insert two check bytes after six message bytes
// R13: Bytes go most significant bit first
// R14: Frame word detection blocked during block check
// R15: Divider cleared per block, remainder sent MSB first
module mbc_top #(
  parameter int BIT_CYC = mbc_pkg::BIT_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Parallel port
  input wire logic [2:0] addr,
  input wire logic strobe,
  input wire logic wr_n,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n,
  // Serial link
  input wire logic rx_bit_in,
  input wire logic rx_frame_found,
  output logic tx_bit_out,
  output logic tx_bit_en,
  // Status
  output logic frame_detect_en,
  output logic low_power
);
  import mbc_pkg::*;

  // ********************************************************************
  // Host port decode
  // ********************************************************************
  logic [7:0] ctrl;
  logic [7:0] tx_buf;
  logic tx_buf_full;
  logic [7:0] rx_buf;
  logic [7:0] synd_low;
  logic [7:0] synd_high;
  logic rx_ready;
  logic rx_pass;
  logic st_read_seen;
  logic strobe_d;
  logic wr_ev;
  logic rd_ev;
  logic wr_ctrl;
  logic wr_tx;
  logic rd_rx;
  logic rd_status;
  logic [7:0] status_word;
  logic [7:0] next_data;
  logic tx_en;
  logic rx_en;
  logic tx_check_en;

  // Strobe edge marks one access per strobe pulse
  assign wr_ev = strobe && !strobe_d && !wr_n;
  assign rd_ev = strobe && !strobe_d && wr_n;
  assign wr_ctrl = wr_ev && (addr == ADDR_CONTROL);
  assign wr_tx = wr_ev && (addr == ADDR_TX_DATA);
  assign rd_rx = rd_ev && (addr == ADDR_RX_DATA);
  assign rd_status = rd_ev && (addr == ADDR_STATUS);
  assign tx_en = ctrl[CTL_TX_EN];
  assign rx_en = ctrl[CTL_RX_EN];
  assign tx_check_en = ctrl[CTL_TX_CHECK];
  assign status_word = {3'h0, 1'b0, !tx_buf_full, 1'b0, rx_pass, rx_ready};
  // Read mux; syndrome bytes are read only, writes there are ignored
  assign next_data = (addr == ADDR_SYND_LOW) ? synd_low :   // see R3
                     (addr == ADDR_SYND_HIGH) ? synd_high :  // see R3
                     (addr == ADDR_RX_DATA) ? rx_buf :
                     (addr == ADDR_STATUS) ? status_word : RESET_BYTE;
  assign data_oe_n = !(strobe && wr_n);
  assign low_power = !tx_en && !rx_en; // see R11

  // Port registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      strobe_d <= 1'b0;
      ctrl <= RESET_BYTE;
      data_out <= RESET_BYTE;
    end else begin
      strobe_d <= strobe;
      data_out <= next_data;
      if (wr_ctrl) begin
        ctrl <= data_in;
      end
    end
  end

  // ********************************************************************
  // Transmit path
  // ********************************************************************
  logic tx_tick;
  logic rx_tick;
  mbc_tx_state_e tx_state;
  logic [7:0] tx_sh;
  logic [2:0] tx_bitn;
  logic [2:0] tx_bytes;
  logic [15:0] tx_word;
  logic [3:0] tx_wbit;
  logic tx_par;
  logic [14:0] tx_rem;
  logic tx_shift;
  logic tx_clear;
  logic tx_last_bit;
  logic [14:0] tx_mod;
  logic [14:0] tx_rem_fin;

  mbc_bitclk #(.CYCLES(BIT_CYC)) u_txclk (
    .sys_clk(sys_clk),
    .rst(rst),
    .run(tx_en),
    .tick(tx_tick)
  );

  assign tx_last_bit = (tx_bitn == 3'h7);
  // Divider sees message bits only, in send order
  assign tx_shift = tx_tick && (tx_state == MBC_TX_DATA) && tx_check_en; // see R5
  assign tx_clear = !tx_en || (tx_state != MBC_TX_DATA); // see R15
  // Last message bit is still entering the divider on the tick that builds the word
  assign tx_rem_fin = {tx_rem[13:0], 1'b0} ^ ((tx_rem[14] ^ tx_sh[7]) ? CRC_POLY : CRC_RESET);
  assign tx_mod = {tx_rem_fin[14:1], !tx_rem_fin[0]}; // see R6

  mbc_lfsr #(.WIDTH(CRC_W)) u_txcrc (
    .sys_clk(sys_clk),
    .rst(rst),
    .clear(tx_clear),
    .shift(tx_shift),
    .din(tx_sh[7]),
    .rem(tx_rem)
  );

  // Serial byte engine; idle line when no data is waiting
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_state <= MBC_TX_IDLE;
      tx_sh <= RESET_BYTE;
      tx_bitn <= 3'h0;
      tx_bytes <= 3'h0;
      tx_word <= 16'h0000;
      tx_wbit <= 4'h0;
      tx_par <= 1'b0;
      tx_buf <= RESET_BYTE;
      tx_buf_full <= 1'b0;
      tx_bit_out <= 1'b0;
    end else if (!tx_en) begin
      tx_state <= MBC_TX_IDLE;
      tx_bytes <= 3'h0;
      tx_par <= 1'b0;
      tx_buf_full <= 1'b0;
      tx_bit_out <= 1'b0;
    end else begin
      if (wr_tx) begin
        tx_buf <= data_in;
        tx_buf_full <= 1'b1;
      end
      if (tx_tick) begin
        unique case (tx_state)
          MBC_TX_IDLE: begin
            if (tx_buf_full && !wr_tx) begin
              tx_sh <= tx_buf;
              tx_buf_full <= 1'b0;
              tx_bitn <= 3'h0;
              tx_state <= MBC_TX_DATA;
            end
          end
          MBC_TX_DATA: begin
            tx_bit_out <= tx_sh[7]; // see R13
            tx_par <= tx_par ^ tx_sh[7];
            tx_sh <= {tx_sh[6:0], 1'b0};
            tx_bitn <= tx_bitn + 3'h1;
            if (tx_last_bit) begin
              if (tx_check_en && tx_bytes == 3'(BLOCK_BYTES - 1)) begin
                // Check word: modified remainder then even parity
                tx_word <= {tx_mod, ^{tx_par, tx_sh[7], tx_mod}}; // see R6, R7, R12
                tx_wbit <= 4'h0;
                tx_bytes <= 3'h0;
                tx_state <= MBC_TX_CHECK;
              end else if (tx_buf_full && !wr_tx) begin
                tx_bytes <= tx_bytes + 3'h1;
                tx_sh <= tx_buf;
                tx_buf_full <= 1'b0;
              end else begin
                // Underrun aborts the partly built block
                tx_bytes <= 3'h0;
                tx_par <= 1'b0;
                tx_state <= MBC_TX_IDLE;
              end
            end
          end
          MBC_TX_CHECK: begin
            tx_bit_out <= tx_word[15]; // see R15
            tx_word <= {tx_word[14:0], 1'b0};
            tx_wbit <= tx_wbit + 4'h1;
            tx_par <= 1'b0;
            if (tx_wbit == 4'hf) begin
              tx_state <= MBC_TX_IDLE;
            end
          end
          default: tx_state <= MBC_TX_IDLE;
        endcase
      end
    end
  end
  assign tx_bit_en = tx_en && (tx_state != MBC_TX_IDLE);

  // ********************************************************************
  // Receive checker
  // ********************************************************************
  logic rx_s1;
  logic rx_s2;
  logic rx_s3;
  logic rx_bit;
  logic rx_active;
  logic [5:0] rx_cnt;
  logic [7:0] rx_sh;
  logic rx_par;
  logic [14:0] rx_rem;
  logic rx_din;
  logic rx_shift;
  logic rx_clear;
  logic rx_byte_end;
  logic rx_block_end;
  logic [14:0] rx_syn;

  // Three-stage sync; a change counts when stages two and three agree
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_s1 <= 1'b0;
      rx_s2 <= 1'b0;
      rx_s3 <= 1'b0;
      rx_bit <= 1'b0;
    end else begin
      rx_s1 <= rx_bit_in;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
      if (rx_s2 == rx_s3) begin
        rx_bit <= rx_s3;
      end
    end
  end

  mbc_bitclk #(.CYCLES(BIT_CYC)) u_rxclk (
    .sys_clk(sys_clk),
    .rst(rst),
    .run(rx_active),
    .tick(rx_tick)
  );

  // Bit 63 enters inverted, bit 64 stays out of the divider
  assign rx_din = (rx_cnt == 6'(BLOCK_BITS - 2)) ? !rx_bit : rx_bit; // see R8
  assign rx_shift = rx_tick && (rx_cnt < 6'(BLOCK_BITS - 1)); // see R8
  assign rx_clear = !rx_active; // see R15
  assign rx_byte_end = rx_tick && (rx_cnt[2:0] == 3'h7);
  assign rx_block_end = rx_tick && (rx_cnt == 6'(BLOCK_BITS - 1));
  // Syndrome bit one is the divider's low bit
  assign rx_syn = rx_rem; // see R1
  assign frame_detect_en = rx_en && !rx_active; // see R14

  mbc_lfsr #(.WIDTH(CRC_W)) u_rxcrc (
    .sys_clk(sys_clk),
    .rst(rst),
    .clear(rx_clear),
    .shift(rx_shift),
    .din(rx_din),
    .rem(rx_rem)
  );

  // Block sequencer started by a frame word from the detector
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_active <= 1'b0;
      rx_cnt <= 6'h00;
      rx_sh <= RESET_BYTE;
      rx_par <= 1'b0;
      rx_buf <= RESET_BYTE;
      rx_ready <= 1'b0;
      rx_pass <= 1'b0;
      st_read_seen <= 1'b0;
      synd_low <= RESET_BYTE;
      synd_high <= RESET_BYTE;
    end else if (!rx_en) begin
      rx_active <= 1'b0;
      rx_cnt <= 6'h00;
      rx_par <= 1'b0;
      rx_ready <= 1'b0;
      rx_pass <= 1'b0;
      st_read_seen <= 1'b0;
    end else begin
      if (rd_status) begin
        st_read_seen <= 1'b1;
      end
      // Status read then data read clears; a new byte wins over the clear
      if (rd_rx && st_read_seen) begin
        rx_ready <= 1'b0;
        rx_pass <= 1'b0;
        st_read_seen <= 1'b0;
      end
      if (rx_frame_found && !rx_active) begin
        rx_active <= 1'b1;
        rx_cnt <= 6'h00;
        rx_par <= 1'b0;
      end
      if (rx_tick) begin
        rx_sh <= {rx_sh[6:0], rx_bit}; // see R13
        rx_cnt <= rx_cnt + 6'h01;
        if (rx_cnt < 6'(BLOCK_BITS - 1)) begin
          rx_par <= rx_par ^ rx_bit; // see R9
        end
      end
      if (rx_byte_end) begin
        rx_buf <= {rx_sh[6:0], rx_bit};
        rx_ready <= 1'b1;
      end
      if (rx_block_end) begin
        // Held until the next block ends, at least eight byte periods later
        synd_low <= rx_syn[7:0]; // see R2, R3
        synd_high <= {rx_par ^ rx_bit, rx_syn[14:8]}; // see R3, R4, R9
        rx_pass <= (rx_syn == CRC_RESET) && (rx_par == rx_bit); // see R10
        rx_active <= 1'b0; // see R14
        rx_cnt <= 6'h00;
        rx_par <= 1'b0;
      end
    end
  end
endmodule
